// *** rcb_reset_ctrl.sv ***
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rcb_regs.svh"
module rcb_reset_ctrl
  import rcb_pkg::*;
#(
  parameter int HOLD_CYCLES = `RCB_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources, asynchronous to clk
  input  wire logic        ext_reset_n,
  input  wire logic        power_on_clear_reset,
  input  wire logic        debugger_reset,
  input  wire logic        watchdog_one_reset,
  input  wire logic        watchdog_two_reset,
  input  wire logic        main_osc_monitor_reset,
  input  wire logic        fast_internal_osc_monitor_reset,
  input  wire logic        pll_monitor_reset,
  // Supply supervision, asynchronous to clk
  input  wire logic        very_low_voltage_detector,
  input  wire logic        core_supply_level,
  // Reset and oscillator control outputs
  output logic             system_reset,
  output logic             power_up_reset,
  output logic             main_osc_enable,
  output logic             main_osc_max_gain
);

  // Counter is 8 bits wide, so the hold count must fit
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin : g_chk
    $error("HOLD_CYCLES must be 1 to 255");
  end

  localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYCLES - 1);

  // Set wins over clear for every sticky flag
  function automatic logic [`RCB_CAUSE_W-1:0] sticky(
    input logic [`RCB_CAUSE_W-1:0] cur,
    input logic [`RCB_CAUSE_W-1:0] set,
    input logic [`RCB_CAUSE_W-1:0] clr
  );
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  // Exact address match on all 32 bits
  function automatic logic hit(
    input logic [31:0] addr,
    input logic [31:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  // Registers
  rcb_state_t                state_r;
  rcb_state_t                state_nxt;
  logic [7:0]                cnt_r;
  logic [7:0]                cnt_nxt;
  logic [`RCB_CAUSE_W-1:0]   cause_r;
  logic [`RCB_CAUSE_W-1:0]   cause_nxt;
  logic                      backup_ram_loss_flag_r;
  logic                      backup_nxt;
  logic                      unlock_r;
  logic                      sw_rst_r;
  logic                      osc_swen_r;
  logic                      osc_swen_nxt;
  logic                      short_stab_r;
  logic                      short_stab_nxt;
  logic                      sys_rst_r;
  logic                      pu_rst_r;
  logic                      osc_en_out_r;
  logic                      osc_gain_out_r;
  logic [31:0]               prdata_r;

  // Synchronised inputs
  logic [`RCB_SYN_W-1:0]     raw_in;
  logic [`RCB_SYN_W-1:0]     syn;

  assign raw_in[`RCB_SYN_EXT_N]  = ext_reset_n;
  assign raw_in[`RCB_SYN_POC]    = power_on_clear_reset;
  assign raw_in[`RCB_SYN_DBG]    = debugger_reset;
  assign raw_in[`RCB_SYN_WD1]    = watchdog_one_reset;
  assign raw_in[`RCB_SYN_WD2]    = watchdog_two_reset;
  assign raw_in[`RCB_SYN_MMON]   = main_osc_monitor_reset;
  assign raw_in[`RCB_SYN_FMON]   = fast_internal_osc_monitor_reset;
  assign raw_in[`RCB_SYN_PMON]   = pll_monitor_reset;
  assign raw_in[`RCB_SYN_VLV]    = very_low_voltage_detector;
  assign raw_in[`RCB_SYN_SUPPLY] = core_supply_level;

  // All sources are pins or other domains, so each crosses two flops
  rcb_sync #(
    .WIDTH     (`RCB_SYN_W),
    .RESET_VAL (`RCB_SYN_RST)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (raw_in),
    .sync_out (syn)
  );

  // Decoded source levels
  wire ext_rst   = ~syn[`RCB_SYN_EXT_N];
  wire poc_rst   = syn[`RCB_SYN_POC];
  wire dbg_rst   = syn[`RCB_SYN_DBG];
  wire wd1_rst   = syn[`RCB_SYN_WD1];
  wire wd2_rst   = syn[`RCB_SYN_WD2];
  wire mmon_rst  = syn[`RCB_SYN_MMON];
  wire fmon_rst  = syn[`RCB_SYN_FMON];
  wire pmon_rst  = syn[`RCB_SYN_PMON];
  wire vlv_low   = syn[`RCB_SYN_VLV];
  wire supply_on = syn[`RCB_SYN_SUPPLY];

  // Power-up reset comes from power-on clear or the debugger
  wire pu_req = poc_rst | dbg_rst;

  // Any source asks for a system reset
  wire sys_req = pu_req | ext_rst | wd1_rst | wd2_rst
               | mmon_rst | fmon_rst | pmon_rst
               | sw_rst_r;

  // APB decode
  wire acc_ph  = psel & penable;
  wire set_ph  = psel & ~penable;
  wire a_cause = hit(paddr, `RCB_CAUSE_OFS);
  wire a_cclr  = hit(paddr, `RCB_CAUSE_CLR_OFS);
  wire a_swrst = hit(paddr, `RCB_SWRST_OFS);
  wire a_prot  = hit(paddr, `RCB_PROTECT_OFS);
  wire a_bkup  = hit(paddr, `RCB_BACKUP_OFS);
  wire a_bclr  = hit(paddr, `RCB_BACKUP_CLR_OFS);
  wire a_otrg  = hit(paddr, `RCB_OSC_TRIG_OFS);
  wire a_octl  = hit(paddr, `RCB_OSC_CTL_OFS);
  wire mapped  = a_cause | a_cclr | a_swrst | a_prot
               | a_bkup | a_bclr | a_otrg | a_octl;
  wire wr_ok   = acc_ph & pwrite & mapped;

  // Byte lanes gate write data, except the protect key compare; a write without lane 0 or 1 changes little
  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                       {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] wdat  = pwdata & wmask;

  // Write strobes per register
  wire cclr_wr = wr_ok & a_cclr;
  wire bclr_wr = wr_ok & a_bclr;
  wire otrg_wr = wr_ok & a_otrg;
  wire octl_wr = wr_ok & a_octl;
  wire prot_wr = wr_ok & a_prot;

  // Trigger only counts after the unlock key; plain writes fall away
  wire sw_trig = wr_ok & a_swrst & unlock_r
               & wdat[`RCB_BIT_SWRST];

  // Cause set and clear vectors
  logic [`RCB_CAUSE_W-1:0] cause_set;
  logic [`RCB_CAUSE_W-1:0] cause_clr;

  // Each source sets only its own bit
  always_comb begin
    cause_set                    = '0;
    cause_set[`RCB_BIT_SW]       = sw_rst_r;
    cause_set[`RCB_BIT_WD1]      = wd1_rst;
    cause_set[`RCB_BIT_WD2]      = wd2_rst;
    cause_set[`RCB_BIT_MAIN_MON] = mmon_rst;
    cause_set[`RCB_BIT_FAST_MON] = fmon_rst;
    cause_set[`RCB_BIT_PLL_MON]  = pmon_rst;
    cause_set[`RCB_BIT_EXT]      = ext_rst;
  end

  // Write-1 clears, only on the clear register
  assign cause_clr = cclr_wr ? wdat[`RCB_CAUSE_W-1:0] : '0;

  // Power-up reset empties the cause register; otherwise flags stick
  always_comb begin
    if (pu_req) begin
      cause_nxt = `RCB_CAUSE_RST;
    end else begin
      cause_nxt = sticky(cause_r, cause_set, cause_clr) & `RCB_CAUSE_MASK;
    end
  end

  // Backup loss flag ignores every reset source
  wire bk_clr = bclr_wr & wdat[`RCB_BIT_BACKUP];
  assign backup_nxt = (backup_ram_loss_flag_r & ~bk_clr) | vlv_low;

  // Oscillator software enable; disable wins over enable in one write
  wire osc_en_trg  = otrg_wr & wdat[`RCB_BIT_OSC_EN_TRG];
  wire osc_dis_trg = otrg_wr & wdat[`RCB_BIT_OSC_DIS_TRG];

  always_comb begin
    if (pu_req) begin
      osc_swen_nxt = 1'b0;
    end else if (osc_dis_trg) begin
      osc_swen_nxt = 1'b0;
    end else if (osc_en_trg) begin
      osc_swen_nxt = 1'b1;
    end else begin
      osc_swen_nxt = osc_swen_r;
    end
  end

  assign short_stab_nxt = octl_wr ? wdat[`RCB_BIT_SHORT_STAB] : short_stab_r;

  // External reset forces the oscillator on at full gain, given supply
  wire osc_force = ext_rst & supply_on;

  // System reset sequencer: stretches the reset after the last source drops
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      RCB_ST_IDLE: begin
        if (sys_req) begin
          state_nxt = RCB_ST_ACTIVE;
        end
      end
      RCB_ST_ACTIVE: begin
        if (!sys_req) begin
          state_nxt = RCB_ST_HOLD;
          cnt_nxt   = HOLD_LAST;
        end
      end
      RCB_ST_HOLD: begin
        if (sys_req) begin
          state_nxt = RCB_ST_ACTIVE;
        end else if (cnt_r == 8'h00) begin
          state_nxt = RCB_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        state_nxt = RCB_ST_ACTIVE;
      end
    endcase
  end

  // Read mux; clear registers and the software reset trigger read as zero
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (a_cause) begin
      rd_word[`RCB_CAUSE_W-1:0] = cause_r;
    end else if (a_prot) begin
      rd_word[`RCB_BIT_UNLOCKED] = unlock_r;
    end else if (a_bkup) begin
      rd_word[`RCB_BIT_BACKUP] = backup_ram_loss_flag_r;
    end else if (a_otrg) begin
      rd_word[`RCB_BIT_OSC_RUN]  = osc_en_out_r;
      rd_word[`RCB_BIT_OSC_SWEN] = osc_swen_r;
    end else if (a_octl) begin
      rd_word[`RCB_BIT_SHORT_STAB] = short_stab_r;
    end
  end

  // Sequencer and reset outputs; bus reset starts with both resets asserted
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r   <= RCB_ST_ACTIVE;
      cnt_r     <= 8'h00;
      sys_rst_r <= 1'b1;
      pu_rst_r  <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      sys_rst_r <= (state_nxt != RCB_ST_IDLE);
      pu_rst_r  <= pu_req;
    end
  end

  // Cause flags and software reset pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      cause_r  <= `RCB_CAUSE_RST;
      sw_rst_r <= 1'b0;
    end else begin
      cause_r  <= cause_nxt;
      sw_rst_r <= sw_trig;
    end
  end

  // Unlock lasts for exactly the next completed write to a mapped address
  always_ff @(posedge clk) begin
    if (reset) begin
      unlock_r <= 1'b0;
    end else if (wr_ok) begin
      unlock_r <= prot_wr & (pwdata == `RCB_PROTECT_KEY);
    end
  end

  // Backup flag: cleared by nothing but software; bus reset marks RAM unknown
  always_ff @(posedge clk) begin
    if (reset) begin
      backup_ram_loss_flag_r <= 1'b1;
    end else begin
      backup_ram_loss_flag_r <= backup_nxt;
    end
  end

  // Oscillator control; system reset leaves it untouched, except power-up reset, which clears the software enable
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_swen_r     <= 1'b0;
      short_stab_r   <= 1'b0;
      osc_en_out_r   <= 1'b0;
      osc_gain_out_r <= 1'b0;
    end else begin
      osc_swen_r     <= osc_swen_nxt;
      short_stab_r   <= short_stab_nxt;
      osc_en_out_r   <= osc_force | osc_swen_nxt;
      osc_gain_out_r <= osc_force | short_stab_nxt;
    end
  end

  // Read data captured in setup so it comes from a flop in access
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
    end else if (set_ph) begin
      prdata_r <= rd_word;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~mapped;
  assign prdata  = prdata_r;

  // Outputs
  assign system_reset      = sys_rst_r;
  assign power_up_reset    = pu_rst_r;
  assign main_osc_enable   = osc_en_out_r;
  assign main_osc_max_gain = osc_gain_out_r;

endmodule : rcb_reset_ctrl
`default_nettype wire

// *** rcb_regs.svh ***
// What this block does
// - Very-low-voltage detection sets the backup RAM loss flag.
// - Backup RAM loss flag stays set until software writes 1 to its clear bit.
// - No reset source changes the backup RAM loss flag; bus reset sets it.
// - Low external reset pin resets the device and sets the external cause flag.
// - External cause flag holds until write-1 clear or a power-up reset.
// - External reset forces maximum oscillator gain while its supply is active.
// - Power-up reset disables the main oscillator, even if software started it, unless external reset forces it on.
// - Oscillator runs while external reset is held with supply active; stops on release if disabled.
// - Gain is forced to maximum in external reset with supply active, then restored after release.
// - Short-stabilize bit: 1 selects maximum gain, 0 normal gain.
// - Write 1 to enable trigger starts oscillator; disable trigger stops it.
// - Each watchdog reset sets its own cause flag and asserts system reset.
// - Watchdog cause flags hold until write-1 clear or a power-up reset.
// - Writing 1 to the software reset trigger resets and sets its cause flag.
// - Software cause flag clears only by write-1 clear or power-up reset.
// - Each clock monitor reset asserts system reset and sets its own flag.
// - Monitor flags clear by writing 1 to clear bit 3, 5 or 6, or power-up.
// - Debugger reset acts as power-up reset, clearing all cause flags.
// - Software reset trigger accepts only writes made through the unlock sequence.
// - Every power-up reset also asserts the system reset.
// - Cause flags accumulate; each source sets only its own flag.
// - The cause clear register always reads as zero.
`ifndef RCB_REGS_SVH
`define RCB_REGS_SVH

// Register byte offsets
`define RCB_CAUSE_OFS       32'h0000_0000
`define RCB_CAUSE_CLR_OFS   32'h0000_0004
`define RCB_SWRST_OFS       32'h0000_0008
`define RCB_PROTECT_OFS     32'h0000_000C
`define RCB_BACKUP_OFS      32'h0000_0010
`define RCB_BACKUP_CLR_OFS  32'h0000_0014
`define RCB_OSC_TRIG_OFS    32'h0000_0018
`define RCB_OSC_CTL_OFS     32'h0000_001C

// Cause register bit positions
`define RCB_BIT_SW          0
`define RCB_BIT_WD1         1
`define RCB_BIT_WD2         2
`define RCB_BIT_MAIN_MON    3
`define RCB_BIT_FAST_MON    5
`define RCB_BIT_PLL_MON     6
`define RCB_BIT_EXT         8
`define RCB_CAUSE_W         9
`define RCB_CAUSE_MASK      9'h16F
`define RCB_CAUSE_RST       9'h000

// Other field positions
`define RCB_BIT_SWRST       0
`define RCB_BIT_UNLOCKED    0
`define RCB_BIT_BACKUP      0
`define RCB_BIT_OSC_EN_TRG  0
`define RCB_BIT_OSC_DIS_TRG 1
`define RCB_BIT_OSC_RUN     0
`define RCB_BIT_OSC_SWEN    1
`define RCB_BIT_SHORT_STAB  0
`define RCB_PROTECT_KEY     32'h0000_00A5

// Synchroniser bit positions and idle levels
`define RCB_SYN_EXT_N       0
`define RCB_SYN_POC         1
`define RCB_SYN_DBG         2
`define RCB_SYN_WD1         3
`define RCB_SYN_WD2         4
`define RCB_SYN_MMON        5
`define RCB_SYN_FMON        6
`define RCB_SYN_PMON        7
`define RCB_SYN_VLV         8
`define RCB_SYN_SUPPLY      9
`define RCB_SYN_W           10
`define RCB_SYN_RST         10'h001

// Timing
`define RCB_CLK_PERIOD_NS   50
`define RCB_HOLD_NS         500
`define RCB_HOLD_CYC        ((`RCB_HOLD_NS + `RCB_CLK_PERIOD_NS - 1) / `RCB_CLK_PERIOD_NS)

`endif

// *** rcb_pkg.sv ***
package rcb_pkg;

  // System reset sequencer states
  typedef enum logic [1:0] {
    RCB_ST_IDLE   = 2'b00,
    RCB_ST_ACTIVE = 2'b01,
    RCB_ST_HOLD   = 2'b10
  } rcb_state_t;

endpackage : rcb_pkg

// *** rcb_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcb_sync #(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : rcb_sync
`default_nettype wire

// *** rcb_reset_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rcb_regs.svh"
module rcb_reset_ctrl_sva #(
  parameter int HOLD_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // Sources
  input wire logic        ext_reset_n,
  input wire logic        debugger_reset,
  input wire logic        watchdog_one_reset,
  input wire logic        core_supply_level,
  // Controls
  input wire logic        system_reset,
  input wire logic        power_up_reset,
  input wire logic        main_osc_enable,
  input wire logic        main_osc_max_gain
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Completed write with lane 0 on
  sequence s_wr(logic [31:0] ofs);
    psel && penable && pwrite && pstrb[0] && paddr == ofs;
  endsequence
  // Pin held long enough to pass the synchroniser
  sequence s_ext_held;
    (!ext_reset_n && core_supply_level)[*5];
  endsequence

  property p_wd_sys;
    $rose(watchdog_one_reset) |-> ##[1:4] system_reset;
  endproperty
  a_wd_sys: assert property (p_wd_sys) else $error("watchdog gave no system reset");
  property p_pu_sys;
    power_up_reset[*2] |-> system_reset;
  endproperty
  a_pu_sys: assert property (p_pu_sys) else $error("power-up without system reset");
  property p_dbg_pu;
    $rose(debugger_reset) |-> ##[1:4] power_up_reset;
  endproperty
  a_dbg_pu: assert property (p_dbg_pu) else $error("debugger gave no power-up reset");
  property p_ext_gain;
    s_ext_held |-> main_osc_max_gain && main_osc_enable;
  endproperty
  a_ext_gain: assert property (p_ext_gain) else $error("pin reset without max gain");
  property p_pu_osc;
    (power_up_reset && ext_reset_n)[*5] |-> !main_osc_enable;
  endproperty
  a_pu_osc: assert property (p_pu_osc) else $error("oscillator runs in power-up");
  property p_clr_zero;
    psel && penable && !pwrite && paddr == `RCB_CAUSE_CLR_OFS |-> prdata == 32'h0000_0000;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear register read non-zero");
  property p_stab;
    s_wr(`RCB_OSC_CTL_OFS) ##0 pwdata[0] |-> ##[1:2] main_osc_max_gain;
  endproperty
  a_stab: assert property (p_stab) else $error("short-stabilize gave no max gain");
  property p_en;
    s_wr(`RCB_OSC_TRIG_OFS) ##0 (pwdata[1:0] == 2'b01 && !power_up_reset) |-> ##[1:2] main_osc_enable;
  endproperty
  a_en: assert property (p_en) else $error("enable trigger ignored");
  property p_dis;
    ext_reset_n[*5] ##0 s_wr(`RCB_OSC_TRIG_OFS) ##0 pwdata[1] |-> ##[1:2] !main_osc_enable;
  endproperty
  a_dis: assert property (p_dis) else $error("disable trigger ignored");
endmodule : rcb_reset_ctrl_sva

bind rcb_reset_ctrl rcb_reset_ctrl_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .ext_reset_n(ext_reset_n), .debugger_reset(debugger_reset),
  .watchdog_one_reset(watchdog_one_reset), .core_supply_level(core_supply_level),
  .system_reset(system_reset), .power_up_reset(power_up_reset),
  .main_osc_enable(main_osc_enable), .main_osc_max_gain(main_osc_max_gain)
);
`default_nettype wire

// *** rcb_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcb_src_model (
  // Clock
  input wire logic       clk,
  // Requests: 0 poc,1 dbg,2 wd1,3 wd2,4 mmon,5 fmon,6 pmon,7 pin,8 vlv
  input wire logic [8:0] req,
  // Source levels
  output logic           ext_reset_n,
  output logic           poc,
  output logic           dbg,
  output logic           wd1,
  output logic           wd2,
  output logic           mmon,
  output logic           fmon,
  output logic           pmon,
  output logic           vlv
);
  logic [8:0] req_r = '0;
  // Sources change only after an edge, like the real on-chip blocks
  always_ff @(posedge clk) req_r <= req;
  // Pin is active low
  assign ext_reset_n = !req_r[7];
  assign {vlv, pmon, fmon, mmon, wd2, wd1, dbg, poc} = {req_r[8], req_r[6:0]};
endmodule : rcb_src_model
`default_nettype wire

// *** reset_cause_and_backup_flag_logic_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rcb_regs.svh"
module reset_cause_and_backup_flag_logic_bench;
  logic        clk, reset, psel, penable, pwrite, supply, err;
  logic [31:0] paddr, pwdata, rd, exp_v;
  logic [3:0]  pstrb;
  logic [8:0]  req;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, sys_rst, pu_rst, osc_en, osc_gain;
  wire logic        ext_n, poc, dbg, wd1, wd2, mmon, fmon, pmon, vlv;
  wire logic [31:0] osc_v = {30'b0, osc_en, osc_gain};
  int failures = 0, n_tests = 0, cyc = 0;
  int src[6] = '{2, 3, 4, 5, 6, 7};
  logic [31:0] bitv[6] = '{32'h2, 32'h4, 32'h8, 32'h20, 32'h40, 32'h100};

  rcb_src_model u_src (.clk(clk), .req(req), .ext_reset_n(ext_n), .poc(poc), .dbg(dbg),
    .wd1(wd1), .wd2(wd2), .mmon(mmon), .fmon(fmon), .pmon(pmon), .vlv(vlv));
  rcb_reset_ctrl #(.HOLD_CYCLES(2)) dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_n),
    .power_on_clear_reset(poc), .debugger_reset(dbg), .watchdog_one_reset(wd1),
    .watchdog_two_reset(wd2), .main_osc_monitor_reset(mmon),
    .fast_internal_osc_monitor_reset(fmon), .pll_monitor_reset(pmon),
    .very_low_voltage_detector(vlv), .core_supply_level(supply), .system_reset(sys_rst),
    .power_up_reset(pu_rst), .main_osc_enable(osc_en), .main_osc_max_gain(osc_gain));

  // One APB transfer; waits on pready, the timeout cuts a hang
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk
  // Hold a source long enough to cross the synchroniser, check system reset
  task automatic pulse(input int b);
    @(posedge clk) req[b] <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'b0, sys_rst}, 32'h1);
    // Only power-on clear (0) and debugger (1) may raise the power-up reset
    chk({31'b0, pu_rst}, (b < 2) ? 32'h1 : 32'h0);
    @(posedge clk) req[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse
  // Pin reset with oscillator state checked during and after
  task automatic ext_hold(input logic [31:0] e_in, input logic [31:0] e_out);
    @(posedge clk) req[7] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(osc_v, e_in);
    @(posedge clk) req[7] <= 1'b0;
    repeat (6) @(posedge clk);
    chk(osc_v, e_out);
  endtask : ext_hold
  task automatic end_of_test;
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard: far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = 4'hF;
    req     = '0;
    supply  = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rdchk(`RCB_BACKUP_OFS, 32'h1);
    apb(1'b1, `RCB_BACKUP_CLR_OFS, 32'h1);
    rdchk(`RCB_BACKUP_OFS, 32'h0);
    @(posedge clk) req[8] <= 1'b1;
    repeat (6) @(posedge clk);
    @(posedge clk) req[8] <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(`RCB_BACKUP_OFS, 32'h1);
    exp_v = 32'h0;
    for (int i = 0; i < 6; i++) begin
      pulse(src[i]);
      exp_v = exp_v | bitv[i];
      rdchk(`RCB_CAUSE_OFS, exp_v);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `RCB_CAUSE_CLR_OFS, bitv[i]);
      exp_v = exp_v & ~bitv[i];
      rdchk(`RCB_CAUSE_OFS, exp_v);
    end
    pulse(2);
    pulse(0);
    rdchk(`RCB_CAUSE_OFS, 32'h0);
    pulse(3);
    pulse(1);
    rdchk(`RCB_CAUSE_OFS, 32'h0);
    rdchk(`RCB_BACKUP_OFS, 32'h1);
    apb(1'b1, `RCB_SWRST_OFS, 32'h1);
    rdchk(`RCB_CAUSE_OFS, 32'h0);
    apb(1'b1, `RCB_PROTECT_OFS, `RCB_PROTECT_KEY);
    rdchk(`RCB_PROTECT_OFS, 32'h1);
    apb(1'b1, `RCB_SWRST_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'b0, sys_rst}, 32'h1);
    rdchk(`RCB_CAUSE_OFS, 32'h1);
    apb(1'b1, `RCB_CAUSE_CLR_OFS, 32'h2);
    rdchk(`RCB_CAUSE_OFS, 32'h1);
    apb(1'b1, `RCB_CAUSE_CLR_OFS, 32'hFFFF_FFFF);
    rdchk(`RCB_CAUSE_OFS, 32'h0);
    rdchk(`RCB_CAUSE_CLR_OFS, 32'h0);
    apb(1'b1, `RCB_OSC_CTL_OFS, 32'h0);
    apb(1'b1, `RCB_OSC_TRIG_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chk(osc_v, 32'h2);
    rdchk(`RCB_OSC_TRIG_OFS, 32'h3);
    ext_hold(32'h3, 32'h2);
    pulse(2);
    chk(osc_v, 32'h2);
    pulse(1);
    chk(osc_v, 32'h0);
    ext_hold(32'h3, 32'h0);
    supply <= 1'b0;
    ext_hold(32'h0, 32'h0);
    supply <= 1'b1;
    apb(1'b1, `RCB_OSC_CTL_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chk(osc_v, 32'h1);
    rdchk(`RCB_OSC_CTL_OFS, 32'h1);
    apb(1'b1, `RCB_OSC_TRIG_OFS, 32'h1);
    apb(1'b1, `RCB_OSC_TRIG_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk(osc_v, 32'h1);
    rdchk(`RCB_OSC_TRIG_OFS, 32'h0);
    apb(1'b1, 32'h0000_0020, 32'h1);
    chk({31'b0, err}, 32'h1);
    apb(1'b1, `RCB_BACKUP_CLR_OFS, 32'h1);
    rdchk(`RCB_BACKUP_OFS, 32'h0);
    // A mapped address must not answer with an error
    chk({31'b0, err}, 32'h0);
    end_of_test();
  end
endmodule : reset_cause_and_backup_flag_logic_bench
`default_nettype wire
